//--- inc/ieb_pkg.sv
// constants shared by the interrupt enable bank and its bus slave
package ieb_pkg;

   localparam int unsigned DATA_W     = 32;
   localparam int unsigned OFS_W      = 8;
   localparam int unsigned IDX_W      = 2;

   // register byte offsets, low address bits only; hsel picks the region
   localparam logic [OFS_W-1:0] OFS_SET_LOW  = 8'h00;
   localparam logic [OFS_W-1:0] OFS_SET_HIGH = 8'h04;
   localparam logic [OFS_W-1:0] OFS_CLR_LOW  = 8'h08;
   localparam logic [OFS_W-1:0] OFS_CLR_HIGH = 8'h0c;

   // word index inside the bank, taken from haddr[3:2]
   localparam logic [IDX_W-1:0] IDX_SET_LOW  = 2'h0;
   localparam logic [IDX_W-1:0] IDX_SET_HIGH = 2'h1;
   localparam logic [IDX_W-1:0] IDX_CLR_LOW  = 2'h2;
   localparam logic [IDX_W-1:0] IDX_CLR_HIGH = 2'h3;

   // implemented interrupt bits of each word, and the enable reset value
   localparam logic [DATA_W-1:0] MASK_LOW   = 32'hffff_ffdf;
   localparam logic [DATA_W-1:0] MASK_HIGH  = 32'h0002_0703;
   localparam logic [DATA_W-1:0] RESET_ENA  = 32'h0000_0000;

   // bus encodings
   localparam logic [1:0] HTRANS_IDLE   = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

endpackage : ieb_pkg

//--- sim/interrupt_enable_bank_bench.sv
// self-checking bench for the interrupt enable bank over its ahb-lite port
module interrupt_enable_bank_bench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [31:0] A_SL = {24'h0, ieb_pkg::OFS_SET_LOW};
   localparam logic [31:0] A_SH = {24'h0, ieb_pkg::OFS_SET_HIGH};
   localparam logic [31:0] A_CL = {24'h0, ieb_pkg::OFS_CLR_LOW};
   localparam logic [31:0] A_CH = {24'h0, ieb_pkg::OFS_CLR_HIGH};

   logic        clk    = 1'b0;
   logic        rst    = 1'b1;
   logic        hsel   = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = ieb_pkg::HTRANS_IDLE;
   logic [2:0]  hsize  = 3'h2;
   logic [31:0] haddr  = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [31:0] ena_low;
   logic [31:0] ena_high;
   logic        rd_due = 1'b0;
   logic [31:0] m_lo   = 32'h0;
   logic [31:0] m_hi   = 32'h0;
   logic [31:0] exp_q[$];
   logic [63:0] en_q[$];
   logic [63:0] en_exp;
   logic        en_due = 1'b0;
   logic [31:0] offs[4] = '{A_SL, A_SH, A_CL, A_CH};
   int          error_cnt  = 0;
   int          n_compared = 0;

   always #12.5 clk = ~clk;

   ieb_top i_dut (
      .i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout),
      .o_hrdata(hrdata), .o_hresp(hresp), .o_enable_low(ena_low),
      .o_enable_high(ena_high)
   );

   ////////////////////////////////////////////////////////////////////////
   task end_of_test;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   task chk_word(input logic [31:0] got, input logic [31:0] exp,
                 input string what);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
         error_cnt++;
      end
   endtask : chk_word

   // reference state: reserved bits never take a one
   function automatic logic [31:0] model_rd(input logic [31:0] a);
      if (a == A_SL || a == A_CL) return m_lo;
      if (a == A_SH || a == A_CH) return m_hi;
      return 32'h0;
   endfunction : model_rd

   task model_wr(input logic [31:0] a, input logic [31:0] d);
      if (a == A_SL) m_lo |= d & ieb_pkg::MASK_LOW;
      if (a == A_SH) m_hi |= d & ieb_pkg::MASK_HIGH;
      if (a == A_CL) m_lo &= ~d;
      if (a == A_CH) m_hi &= ~d;
   endtask : model_wr

   // software keeps unused bits of every enable word written as zero
   function automatic logic [31:0] keep_zero(input logic [31:0] a,
                                             input logic [31:0] d);
      if (a == A_SL || a == A_CL) return d & ieb_pkg::MASK_LOW;
      if (a == A_SH || a == A_CH) return d & ieb_pkg::MASK_HIGH;
      return d;
   endfunction : keep_zero

   // bounded wait for hready sampled high at a rising edge
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 16);
      if (hreadyout !== 1'b1) begin
         $display("[ERR] %0t bus never ready", $time);
         error_cnt++;
         end_of_test;
      end
   endtask : wait_rdy

   // one single-word transfer; a write leaves a note of both enable words
   // for the watcher, which looks one edge after the data phase
   task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= ieb_pkg::HTRANS_NONSEQ;
      if (!wr) exp_q.push_back(model_rd(a));
      wait_rdy;
      hsel   <= 1'b0;
      htrans <= ieb_pkg::HTRANS_IDLE;
      hwdata <= wr ? keep_zero(a, d) : ~hwdata;
      rd_due <= !wr;
      wait_rdy;
      rd_due <= 1'b0;
      if (wr) begin
         model_wr(a, keep_zero(a, d));
         en_q.push_back({m_hi, m_lo});
         en_due <= 1'b1;
         @(posedge clk);
         en_due <= 1'b0;
      end
   endtask : bus

   // read results and enable notes are judged here, oldest note first
   always @(posedge clk) begin
      if (rd_due === 1'b1 && hreadyout === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk_word(32'h1, 32'h0, "unexpected read");
         end else begin
            chk_word(hrdata, exp_q.pop_front(), "read");
         end
         chk_word({31'h0, hresp}, 32'h0, "resp");
      end
      if (en_due === 1'b1) begin
         if (en_q.size() == 0) begin
            chk_word(32'h1, 32'h0, "unexpected enables");
         end else begin
            en_exp = en_q.pop_front();
            chk_word(ena_low, en_exp[31:0], "enable low");
            chk_word(ena_high, en_exp[63:32], "enable high");
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(56967));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) bus(1'b0, offs[i], 32'h0);
      chk_word(ena_low | ena_high, 32'h0, "reset enables");
      $display("test reset done");
      bus(1'b1, A_SL, 32'hffff_ffff);
      bus(1'b1, A_SH, 32'hffff_ffff);
      bus(1'b1, A_CL, $urandom);
      bus(1'b1, A_CH, $urandom);
      for (int i = 0; i < 4; i++) bus(1'b0, offs[i], 32'h0);
      $display("test set and clear done");
      for (int i = 0; i < 32; i++) begin
         bus(1'b1, A_CL, 32'hffff_ffff);
         bus(1'b1, A_CH, 32'hffff_ffff);
         bus(1'b1, A_SL, 32'h1 << i);
         bus(1'b1, A_SH, 32'h1 << i);
         bus(1'b0, offs[i % 4], 32'h0);
      end
      $display("test walking bit done");
      repeat (40) begin
         bus(1'b1, offs[$urandom % 4], $urandom);
         bus(1'b0, offs[$urandom % 4], 32'h0);
      end
      $display("test random done");
      bus(1'b1, A_CL, 32'hffff_ffff);
      bus(1'b1, 32'h0000_0010, 32'hffff_ffff);
      bus(1'b1, 32'h0000_0001, 32'hffff_ffff);
      bus(1'b0, 32'h0000_0010, 32'h0);
      $display("test unmapped done");
      bus(1'b1, A_SL, 32'hffff_ffff);
      bus(1'b1, A_SH, 32'hffff_ffff);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      m_lo = 32'h0;
      m_hi = 32'h0;
      @(negedge clk);
      chk_word(ena_low | ena_high, 32'h0, "mid reset");
      bus(1'b0, A_SL, 32'h0);
      bus(1'b0, A_CH, 32'h0);
      $display("test second reset done");
      end_of_test;
   end

endmodule : interrupt_enable_bank_bench

//--- verilog/ieb_ahb_slave.sv
// ahb-lite address phase capture for the enable bank, zero wait states
module ieb_ahb_slave (
   input  wire logic                      i_clk,
   input  wire logic                      i_rst,
   input  wire logic                      i_hsel,
   input  wire logic [ieb_pkg::OFS_W-1:0] i_haddr,
   input  wire logic [1:0]                i_htrans,
   input  wire logic                      i_hwrite,
   input  wire logic                      i_hready,
   output logic                           o_rd_take,
   output logic      [ieb_pkg::IDX_W-1:0] o_rd_idx,
   output logic                           o_rd_mapped,
   output logic                           o_wr_pend,
   output logic      [ieb_pkg::IDX_W-1:0] o_wr_idx
);

   logic                      take;
   logic                      mapped;
   logic                      wr_pend_reg;
   logic                      wr_pend_next;
   logic [ieb_pkg::IDX_W-1:0] wr_idx_reg;

   // a transfer is taken when selected, active and the bus is ready;
   // seq is accepted like nonseq since only single words are expected
   assign take         = i_hsel & i_htrans[1] & i_hready;
   assign mapped       = (i_haddr[ieb_pkg::OFS_W-1:4] == 4'h0)
                         & (i_haddr[1:0] == 2'h0);
   assign o_rd_take    = take & ~i_hwrite;
   assign o_rd_idx     = i_haddr[3:2];
   assign o_rd_mapped  = mapped;
   assign wr_pend_next = take & i_hwrite & mapped;
   assign o_wr_pend    = wr_pend_reg;
   assign o_wr_idx     = wr_idx_reg;

   // write address held for the data phase; unmapped writes are dropped
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg  <= ieb_pkg::IDX_SET_LOW;
      end else if (i_hready) begin
         wr_pend_reg <= wr_pend_next;
         wr_idx_reg  <= i_haddr[3:2];
      end
   end

endmodule : ieb_ahb_slave

//--- verilog/ieb_enable_word.sv
// one word of interrupt enable bits with write-one-set and write-one-clear
module ieb_enable_word #(
   parameter logic [31:0] IMPL_MASK = 32'hffff_ffff
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [31:0] i_set_bits,
   input  wire logic [31:0] i_clr_bits,
   output logic      [31:0] o_enable,
   output logic      [31:0] o_enable_next
);

   logic [31:0] enable_reg;

   // set beats clear so an enable written in the same cycle is never lost;
   // unimplemented positions are forced to zero whatever software writes
   assign o_enable_next = ((enable_reg & ~i_clr_bits) | i_set_bits)
                          & IMPL_MASK;
   assign o_enable      = enable_reg;

   // enable storage
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         enable_reg <= ieb_pkg::RESET_ENA;
      end else begin
         enable_reg <= o_enable_next;
      end
   end

endmodule : ieb_enable_word

//--- verilog/ieb_top.sv
// interrupt enable bank: two shared enable words seen through set and clear
module ieb_top (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic      [31:0] o_hrdata,
   output logic             o_hresp,
   output logic      [31:0] o_enable_low,
   output logic      [31:0] o_enable_high
);

   ////////////////////////////////////////////////////////////////////////
   // declarations

   logic                      rd_take;
   logic [ieb_pkg::IDX_W-1:0] rd_idx;
   logic                      rd_mapped;
   logic                      wr_pend;
   logic [ieb_pkg::IDX_W-1:0] wr_idx;
   logic                      wr_set_low;
   logic                      wr_set_high;
   logic                      wr_clr_low;
   logic                      wr_clr_high;
   logic [31:0]               set_low_bits;
   logic [31:0]               set_high_bits;
   logic [31:0]               clr_low_bits;
   logic [31:0]               clr_high_bits;
   logic [31:0]               low_next;
   logic [31:0]               high_next;
   logic [31:0]               rd_value;
   logic [31:0]               hrdata_reg;
   logic                      hreadyout_reg;
   logic                      hresp_reg;
   logic [2:0]                hsize_unused;

   ////////////////////////////////////////////////////////////////////////
   // bus slave

   // only whole words are supported, so the transfer size is not decoded
   assign hsize_unused = i_hsize;

   ieb_ahb_slave u_slave (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_hsel      (i_hsel),
      .i_haddr     (i_haddr[ieb_pkg::OFS_W-1:0]),
      .i_htrans    (i_htrans),
      .i_hwrite    (i_hwrite),
      .i_hready    (i_hready),
      .o_rd_take   (rd_take),
      .o_rd_idx    (rd_idx),
      .o_rd_mapped (rd_mapped),
      .o_wr_pend   (wr_pend),
      .o_wr_idx    (wr_idx)
   );

   ////////////////////////////////////////////////////////////////////////
   // write strobes for the data phase

   // each view of a word gets its own strobe; one write touches one view
   assign wr_set_low  = wr_pend & (wr_idx == ieb_pkg::IDX_SET_LOW);
   assign wr_set_high = wr_pend & (wr_idx == ieb_pkg::IDX_SET_HIGH);
   assign wr_clr_low  = wr_pend & (wr_idx == ieb_pkg::IDX_CLR_LOW);
   assign wr_clr_high = wr_pend & (wr_idx == ieb_pkg::IDX_CLR_HIGH);

   // a zero bit yields no set and no clear, so the enable keeps its value
   assign set_low_bits  = wr_set_low  ? i_hwdata : 32'h0000_0000;
   assign set_high_bits = wr_set_high ? i_hwdata : 32'h0000_0000;
   assign clr_low_bits  = wr_clr_low  ? i_hwdata : 32'h0000_0000;
   assign clr_high_bits = wr_clr_high ? i_hwdata : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // enable storage, one instance per word

   ieb_enable_word #(
      .IMPL_MASK (ieb_pkg::MASK_LOW)
   ) u_word_low (
      .i_clk         (i_clk),
      .i_rst         (i_rst),
      .i_set_bits    (set_low_bits),
      .i_clr_bits    (clr_low_bits),
      .o_enable      (o_enable_low),
      .o_enable_next (low_next)
   );

   ieb_enable_word #(
      .IMPL_MASK (ieb_pkg::MASK_HIGH)
   ) u_word_high (
      .i_clk         (i_clk),
      .i_rst         (i_rst),
      .i_set_bits    (set_high_bits),
      .i_clr_bits    (clr_high_bits),
      .o_enable      (o_enable_high),
      .o_enable_next (high_next)
   );

   ////////////////////////////////////////////////////////////////////////
   // read path

   // reads look at the next state: a read address phase overlaps the data
   // phase of a preceding write, and must already see that write
   assign rd_value = !rd_mapped ? 32'h0000_0000 :
                     (rd_idx[0] ? high_next : low_next);

   // read data register, loaded at the end of the address phase
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (rd_take) begin
         hrdata_reg <= rd_value;
      end
   end

   // the bank never stalls and never errors, so ready and okay are fixed
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         hreadyout_reg <= 1'b1;
         hresp_reg     <= ieb_pkg::HRESP_OKAY;
      end else begin
         hreadyout_reg <= 1'b1;
         hresp_reg     <= ieb_pkg::HRESP_OKAY;
      end
   end

   assign o_hrdata    = hrdata_reg;
   assign o_hreadyout = hreadyout_reg;
   assign o_hresp     = hresp_reg;

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge i_clk);
   endclocking

   default disable iff (i_rst);

   // a write strobe marks the data phase, so a |=> on it looks just after
   // the edge that stores the word; read checks look in the data phase,
   // where the master takes the word

   // every one written to an implemented bit of the low set view is enabled one edge later
   a_set_low_on: assert property (
      wr_set_low |=>
         ((o_enable_low & $past(i_hwdata) & ieb_pkg::MASK_LOW)
          == ($past(i_hwdata) & ieb_pkg::MASK_LOW)))
      else $error("set-enable low write did not enable written bits");

   // zero bits of a set write keep the old enable value
   a_set_zero_keeps: assert property (
      wr_set_low |=>
         ((o_enable_low & ~$past(i_hwdata))
          == ($past(o_enable_low) & ~$past(i_hwdata))))
      else $error("set-enable low write changed a bit written as zero");

   // a high word set write behaves the same for its implemented bits
   a_set_high_on: assert property (
      wr_set_high |=>
         ((o_enable_high & $past(i_hwdata) & ieb_pkg::MASK_HIGH)
          == ($past(i_hwdata) & ieb_pkg::MASK_HIGH))
         && ((o_enable_high & ~$past(i_hwdata))
             == ($past(o_enable_high) & ~$past(i_hwdata))))
      else $error("set-enable high write gave wrong enables");

   // a write to the high word never disturbs the low word
   a_word_isolated: assert property (
      (wr_set_high || wr_clr_high) |=>
         (o_enable_low == $past(o_enable_low)))
      else $error("high word write changed low word enables");

   // bit 5 of the low word never holds an enable
   a_low_bit5_zero: assert property (
      o_enable_low[5] == 1'b0)
      else $error("low word bit 5 became set");

   // unimplemented high bits stay zero and read as zero
   a_high_gaps_zero: assert property (
      (o_enable_high & ~ieb_pkg::MASK_HIGH) == 32'h0000_0000)
      else $error("unimplemented high word bit became set");

   // a one written to the clear view disables within one edge
   a_clear_turns_off: assert property (
      (wr_clr_low || wr_clr_high) |=>
         ((o_enable_low & $past(i_hwdata) & {32{$past(wr_clr_low)}})
          == 32'h0000_0000)
         && ((o_enable_high & $past(i_hwdata) & {32{$past(wr_clr_high)}})
             == 32'h0000_0000))
      else $error("clear-enable write left a written bit enabled");

   // clear write keeps bits written as zero
   a_clear_zero_keeps: assert property (
      wr_clr_low |=>
         ((o_enable_low & ~$past(i_hwdata))
          == ($past(o_enable_low) & ~$past(i_hwdata))))
      else $error("clear-enable write changed a bit written as zero");

   // a read of a set view returns the live enable word in its data phase
   a_read_set_state: assert property (
      (rd_take && rd_mapped && !rd_idx[1]) |=>
         (o_hrdata == ($past(rd_idx[0]) ? o_enable_high : o_enable_low)) ##0
         (o_hreadyout && (o_hresp == ieb_pkg::HRESP_OKAY)))
      else $error("set-enable read returned wrong state");

   // the clear view reads the very same shared state
   a_read_clr_state: assert property (
      (rd_take && rd_mapped && rd_idx[1]) |=>
         (o_hrdata == ($past(rd_idx[0]) ? o_enable_high : o_enable_low)))
      else $error("clear-enable read differs from shared enable state");

   // reset leaves every enable off at the first edge after it
   a_reset_all_off: assert property (disable iff (1'b0)
      i_rst |=> (o_enable_low == 32'h0000_0000)
                && (o_enable_high == 32'h0000_0000))
      else $error("enables not cleared by reset");

   // unmapped reads answer zero
   a_unmapped_zero: assert property (
      (rd_take && !rd_mapped) |=> (o_hrdata == 32'h0000_0000))
      else $error("unmapped read returned nonzero data");

   // a clear write to the high word keeps bits written as zero
   a_clear_high_keeps: assert property (
      wr_clr_high |=>
         ((o_enable_high & ~$past(i_hwdata))
          == ($past(o_enable_high) & ~$past(i_hwdata))))
      else $error("clear-enable high write changed a bit written as zero");

   // a write to the low word never disturbs the high word
   a_low_isolated: assert property (
      (wr_set_low || wr_clr_low) |=>
         (o_enable_high == $past(o_enable_high)))
      else $error("low word write changed high word enables");

   // without a write in its data phase no enable may move
   a_idle_stable: assert property (
      !wr_pend |=>
         ((o_enable_low == $past(o_enable_low))
          && (o_enable_high == $past(o_enable_high))))
      else $error("enables changed without a write");

   // a read alone never moves an enable
   a_read_no_effect: assert property (
      (rd_take && !wr_pend) |=>
         ((o_enable_low == $past(o_enable_low))
          && (o_enable_high == $past(o_enable_high))))
      else $error("read changed the enable state");

   // the bank always answers at once and always with okay
   a_ready_okay: assert property (
      o_hreadyout && (o_hresp == ieb_pkg::HRESP_OKAY))
      else $error("bus response not ready or not okay");

   // read data stands until the next read address phase is taken
   a_rdata_holds: assert property (
      !rd_take |=> $stable(o_hrdata))
      else $error("read data changed without a read");

   // a read of the high word never shows an unimplemented bit
   a_high_read_gaps: assert property (
      (rd_take && rd_mapped && rd_idx[0]) |=>
         ((o_hrdata & ~ieb_pkg::MASK_HIGH) == 32'h0000_0000))
      else $error("high word read showed an unimplemented bit");

   // a read of the low word never shows bit 5
   a_low_read_gap: assert property (
      (rd_take && rd_mapped && !rd_idx[0]) |=> (o_hrdata[5] == 1'b0))
      else $error("low word read showed bit 5 set");

   // a write outside the bank leaves no write pending
   a_unmapped_write: assert property (
      (i_hsel && i_htrans[1] && i_hready && i_hwrite && !rd_mapped) |=>
         !wr_pend)
      else $error("unmapped write reached the enable words");

   // every taken write to a mapped word reaches its data phase strobe
   a_write_strobed: assert property (
      (i_hsel && i_htrans[1] && i_hready && i_hwrite && rd_mapped) |=>
         wr_pend)
      else $error("mapped write was not carried into its data phase");

   // a write strobe only ever follows a taken write address phase
   a_strobe_from_take: assert property (
      wr_pend |-> ($past(i_hsel) && $past(i_htrans[1]) && $past(i_hwrite)))
      else $error("write strobe without a taken write address phase");

   // reset also clears the read data and leaves the bus ready
   a_reset_bus_idle: assert property (disable iff (1'b0)
      i_rst |=> (o_hrdata == 32'h0000_0000) && o_hreadyout
                && (o_hresp == ieb_pkg::HRESP_OKAY))
      else $error("bus outputs not idle after reset");

   c_set_low: cover property (wr_set_low ##1 (o_enable_low != 32'h0));
   c_clear_low: cover property (
      (o_enable_low != 32'h0) ##1 wr_clr_low ##1 (o_enable_low == 32'h0));
   c_set_high: cover property (wr_set_high ##1 o_enable_high[17]);
   c_write_then_read: cover property (wr_set_low ##[1:4] rd_take);
   c_clear_high: cover property (wr_clr_high ##1 (o_enable_high == 32'h0));

endmodule : ieb_top
